// File: verilog/arr_defines.svh
// Purpose: Offsets, field positions, reset values for result readout block
// Assumes: 8-bit register addresses from the serial command decoder
// Notes: Included by the integrity and readout design files
`ifndef ARR_DEFINES_SVH
`define ARR_DEFINES_SVH
`define ARR_ADDR_IFMODE      8'h02
`define ARR_ADDR_CHECKSUM    8'h03
`define ARR_ADDR_RESULT      8'h04
`define ARR_ADDR_STATUS      8'h00
`define ARR_BIT_APPEND       6
`define ARR_BIT_INTEG_EN     5
`define ARR_BIT_CSUM_HI      3
`define ARR_BIT_CSUM_LO      2
`define ARR_BIT_SHORT_WORD   0
`define ARR_IFMODE_WMASK     16'hFFED
`define ARR_IFMODE_RESET     16'h0000
`define ARR_RESULT_RESET     24'h000000
`define ARR_CHECKSUM_RESET   24'h000000
`define ARR_STAT_RDY_BIT     7
`define ARR_STAT_INTEG_BIT   3
`endif

// File: verilog/arr_pkg.sv
// Purpose: Types for result readout block
// Assumes: Nothing
// Notes: Constants live in arr_defines.svh
package arr_pkg;
  typedef enum logic [1:0]
  {
    ARR_CSUM_OFF  = 2'b00,
    ARR_CSUM_XOR  = 2'b01,
    ARR_CSUM_CRC  = 2'b10,
    ARR_CSUM_RSVD = 2'b11
  } arr_csum_mode_t;
  typedef enum logic [1:0]
  {
    ARR_RD_IDLE   = 2'b00,
    ARR_RD_ACTIVE = 2'b01
  } arr_rd_state_t;
endpackage

// File: verilog/arr_integrity.sv
// Purpose: XOR checksum over monitored registers and change detection
// Assumes: Monitored words presented flat, 24 bits each
// Notes: Reference captured on the enable edge
`timescale 1ns/1ps
`include "arr_defines.svh"
module arr_integrity
  import arr_pkg::*;
#(
  parameter int NUM_REGS = 5
)
(
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // Control
  input  wire logic                     enable,
  input  wire logic [NUM_REGS*24-1:0]   watched,
  // Results
  output logic      [23:0]              checksum_q,
  output logic                          mismatch
);
  logic [23:0] sum_d;
  logic [23:0] ref_q;
  logic        en_q;
  always_comb
  begin
    sum_d = 24'h000000;
    for (int i = 0; i < NUM_REGS; i++)
      sum_d = sum_d ^ watched[i*24 +: 24];
  end
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      en_q <= 1'b0;
    else
      en_q <= enable;
  end
  // Reference taken on the rising enable so later edits show up
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ref_q <= `ARR_CHECKSUM_RESET;
    else if (enable && !en_q)
      ref_q <= sum_d;
  end
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      checksum_q <= `ARR_CHECKSUM_RESET;
    else if (enable)
      checksum_q <= sum_d;
    else
      checksum_q <= 24'h000000;
  end
  assign mismatch = enable && en_q && (sum_d != ref_q);
endmodule

// File: verilog/arr_format.sv
// Purpose: Shape a raw conversion into the stored result word
// Assumes: Raw value is 24-bit offset binary
// Notes: Combinational only
`timescale 1ns/1ps
module arr_format
  import arr_pkg::*;
(
  // Raw sample
  input  wire logic [23:0] raw,
  input  wire logic        polarity_select,
  input  wire logic        short_word_select,
  // Shaped word
  output logic      [23:0] shaped
);
  logic [23:0] coded;
  // polarity_select high shifts the raw word right by one bit; low passes it straight
  always_comb
  begin
    coded = polarity_select ? {1'b0, raw[23:1]} : raw;
    shaped = short_word_select ? {8'h00, coded[23:8]} : coded;
  end
endmodule

// File: verilog/arr_readout.sv
// Purpose: Interface mode bits, checksum register and result register
// Assumes: A serial front end decodes register reads and writes on sys_clk
// Notes: Front end stretches frames by one byte when xfer_extra_byte is high
`timescale 1ns/1ps
`include "arr_defines.svh"
module arr_readout
  import arr_pkg::*;
#(
  parameter int NUM_REGS = 5
)
(
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // Register access from serial front end
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd_start,
  input  wire logic                   reg_rd_end,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [15:0]            reg_wdata,
  output logic      [31:0]            reg_rdata_q,
  output logic      [5:0]             reg_rlen_q,
  // Transfer protection
  output logic                        xfer_extra_byte_q,
  output logic                        rd_use_xor_q,
  output logic                        rd_use_crc_q,
  output logic                        wr_use_crc_q,
  // Converter side
  input  wire logic                   conv_valid,
  input  wire logic [23:0]            conv_raw,
  input  wire logic                   polarity_select,
  input  wire logic [7:0]             conv_status,
  input  wire logic [NUM_REGS*24-1:0] watched_regs,
  // Status outputs
  output logic                        ready_n_q,
  output logic                        integ_error_q,
  output logic      [15:0]            ifmode_q
);
  arr_rd_state_t  rd_state_q;
  arr_csum_mode_t csum_mode;
  logic [23:0]    result_q;
  logic [7:0]     status_snap_q;
  logic           result_short_q;
  logic [23:0]    shaped;
  logic [23:0]    checksum;
  logic           mismatch;
  logic           ifmode_wr;
  logic           result_rd;
  logic [7:0]     status_word;
  logic           integ_off_wr;
  logic [31:0]    rd_word_d;
  logic [5:0]     rd_len_d;

  // Address match shared by the mode write and result read decodes below
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
  begin
    addr_hit = (addr == target);
  end
  endfunction

  // One accept decode for result load and ready drop, so the two never drift apart
  function automatic logic load_ok(input logic valid, input arr_rd_state_t state, input logic rd_now);
  begin
    load_ok = valid && (state == ARR_RD_IDLE) && !rd_now;
  end
  endfunction

  // Bit count of a result read from stored length and append option
  function automatic logic [5:0] result_len(input logic short_word, input logic append);
  begin
    if (short_word)
      result_len = append ? 6'h18 : 6'h10;
    else
      result_len = append ? 6'h20 : 6'h18;
  end
  endfunction

  assign ifmode_wr    = reg_wr && addr_hit(reg_addr, `ARR_ADDR_IFMODE);
  assign result_rd    = reg_rd_start && addr_hit(reg_addr, `ARR_ADDR_RESULT);
  assign integ_off_wr = ifmode_wr && !reg_wdata[`ARR_BIT_INTEG_EN];
  assign csum_mode = arr_csum_mode_t'(ifmode_q[`ARR_BIT_CSUM_HI:`ARR_BIT_CSUM_LO]);

  // Monitored set excludes mode, result and status, which the caller wires
  arr_integrity #(
    .NUM_REGS (NUM_REGS)
  ) u_integrity (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .enable     (ifmode_q[`ARR_BIT_INTEG_EN]),
    .watched    (watched_regs),
    .checksum_q (checksum),
    .mismatch   (mismatch)
  );

  // Word size tracks the short-word mode at conversion time, not at read time
  arr_format u_format (
    .raw               (conv_raw),
    .polarity_select   (polarity_select),
    .short_word_select (ifmode_q[`ARR_BIT_SHORT_WORD]),
    .shaped            (shaped)
  );

  // Reserved bits 4 and 1 masked off so they read zero
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ifmode_q <= `ARR_IFMODE_RESET;
    else if (ifmode_wr)
      ifmode_q <= reg_wdata & `ARR_IFMODE_WMASK;
  end

  // Error is sticky; mismatch is a level while enabled, so the disabling write wins or the flag never clears
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      integ_error_q <= 1'b0;
    else if (integ_off_wr)
      integ_error_q <= 1'b0;
    else if (mismatch)
      integ_error_q <= 1'b1;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      xfer_extra_byte_q <= 1'b0;
      rd_use_xor_q      <= 1'b0;
      rd_use_crc_q      <= 1'b0;
      wr_use_crc_q      <= 1'b0;
    end
    else
    begin
      case (csum_mode)
        ARR_CSUM_XOR:
        begin
          xfer_extra_byte_q <= 1'b1;
          rd_use_xor_q      <= 1'b1;
          rd_use_crc_q      <= 1'b0;
          wr_use_crc_q      <= 1'b1;
        end
        ARR_CSUM_CRC:
        begin
          xfer_extra_byte_q <= 1'b1;
          rd_use_xor_q      <= 1'b0;
          rd_use_crc_q      <= 1'b1;
          wr_use_crc_q      <= 1'b1;
        end
        default:
        begin
          xfer_extra_byte_q <= 1'b0;
          rd_use_xor_q      <= 1'b0;
          rd_use_crc_q      <= 1'b0;
          wr_use_crc_q      <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rd_state_q <= ARR_RD_IDLE;
    else
    begin
      case (rd_state_q)
        ARR_RD_IDLE:
          if (result_rd)
            rd_state_q <= ARR_RD_ACTIVE;
        ARR_RD_ACTIVE:
          if (reg_rd_end)
            rd_state_q <= ARR_RD_IDLE;
        default:
          rd_state_q <= ARR_RD_IDLE;
      endcase
    end
  end

  // Conversion arriving during a result read is dropped, not queued
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      result_q       <= `ARR_RESULT_RESET;
      result_short_q <= 1'b0;
      status_snap_q  <= 8'h00;
    end
    else if (load_ok(conv_valid, rd_state_q, result_rd))
    begin
      result_q       <= shaped;
      result_short_q <= ifmode_q[`ARR_BIT_SHORT_WORD];
      status_snap_q  <= conv_status;
    end
  end

  // Result read raises ready; a new result lowers it
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ready_n_q <= 1'b1;
    else if (result_rd)
      ready_n_q <= 1'b1;
    else if (load_ok(conv_valid, rd_state_q, result_rd))
      ready_n_q <= 1'b0;
  end

  always_comb
  begin
    status_word = status_snap_q;
    status_word[`ARR_STAT_RDY_BIT]   = ready_n_q;
    status_word[`ARR_STAT_INTEG_BIT] = integ_error_q;
  end

  // Read word built combinationally; length follows the held result's word size and the current append bit
  always_comb
  begin
    rd_word_d = 32'h00000000;
    rd_len_d  = 6'h00;
    case (reg_addr)
      `ARR_ADDR_RESULT:
      begin
        if (ifmode_q[`ARR_BIT_APPEND])
        begin
          rd_word_d = result_short_q ? {8'h00, result_q[15:0], status_word}
                                     : {result_q, status_word};
        end
        else
        begin
          rd_word_d = {8'h00, result_q};
        end
        rd_len_d = result_len(result_short_q, ifmode_q[`ARR_BIT_APPEND]);
      end
      `ARR_ADDR_CHECKSUM:
      begin
        rd_word_d = {8'h00, checksum};
        rd_len_d  = 6'h18;
      end
      `ARR_ADDR_IFMODE:
      begin
        rd_word_d = {16'h0000, ifmode_q};
        rd_len_d  = 6'h10;
      end
      `ARR_ADDR_STATUS:
      begin
        rd_word_d = {24'h000000, status_word};
        rd_len_d  = 6'h08;
      end
      default:
      begin
        rd_word_d = 32'h00000000;
        rd_len_d  = 6'h00;
      end
    endcase
  end

  // Read data is right-aligned; reg_rlen_q gives the bit count
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata_q <= 32'h00000000;
      reg_rlen_q  <= 6'h00;
    end
    else if (reg_rd_start)
    begin
      reg_rdata_q <= rd_word_d;
      reg_rlen_q  <= rd_len_d;
    end
  end
endmodule

// File: test/arr_readout_props.sv
// Purpose: Port assertions for arr_readout
// Assumes: Result at 8'h04, mode at 8'h02
// Notes: Bound from the bench
`timescale 1ns/1ps
module arr_readout_props
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Register frames
  input wire logic        reg_wr,
  input wire logic        reg_rd_start,
  input wire logic        reg_rd_end,
  input wire logic        conv_valid,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [5:0]  reg_rlen_q,
  // Levels
  input wire logic        xfer_extra_byte_q,
  input wire logic        rd_use_xor_q,
  input wire logic        rd_use_crc_q,
  input wire logic        wr_use_crc_q,
  input wire logic        ready_n_q,
  input wire logic        integ_error_q,
  input wire logic [15:0] ifmode_q
);
  logic rd_res;
  logic in_rd_q;
  logic short_held_q;
  assign rd_res = reg_rd_start && reg_addr == 8'h04;
  // Open result read, closed by the frame end
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      in_rd_q <= 1'b0;
    else if (rd_res)
      in_rd_q <= 1'b1;
    else if (reg_rd_end)
      in_rd_q <= 1'b0;
  // Held result keeps the word length chosen when it was converted
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      short_held_q <= 1'b0;
    else if (conv_valid && !in_rd_q && !rd_res)
      short_held_q <= ifmode_q[0];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_len;
    rd_res |=> reg_rlen_q == ($past(ifmode_q[6]) ? 6'h08 : 6'h00) + ($past(short_held_q) ? 6'h10 : 6'h18);
  endproperty
  a_len: assert property (p_len) else $error("result read length wrong");
  property p_rdy;
    rd_res |=> ready_n_q;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready not raised by result read");
  property p_hold;
    in_rd_q |-> ready_n_q;
  endproperty
  a_hold: assert property (p_hold) else $error("result loaded during read");
  property p_clr;
    reg_wr && reg_addr == 8'h02 && !reg_wdata[5] |=> !integ_error_q;
  endproperty
  a_clr: assert property (p_clr) else $error("integrity error not cleared");
  property p_set;
    $rose(integ_error_q) |-> $past(ifmode_q[5]);
  endproperty
  a_set: assert property (p_set) else $error("integrity error while disabled");
  property p_xb;
    reg_wr && reg_addr == 8'h02 ##1 !reg_wr |=> xfer_extra_byte_q == ($past(reg_wdata[3], 2) ^ $past(reg_wdata[2], 2));
  endproperty
  a_xb: assert property (p_xb) else $error("extra byte level wrong");
  property p_mode;
    reg_wr && reg_addr == 8'h02 ##1 !reg_wr |=> rd_use_xor_q == ($past(reg_wdata[3:2], 2) == 2'h1)
      && rd_use_crc_q == ($past(reg_wdata[3:2], 2) == 2'h2) && wr_use_crc_q == (rd_use_xor_q || rd_use_crc_q);
  endproperty
  a_mode: assert property (p_mode) else $error("protection scheme wrong");
  property p_rsv;
    !ifmode_q[4] && !ifmode_q[1];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved mode bit set");
endmodule

// File: test/arr_host.sv
// Purpose: Host model issuing register frames
// Assumes: One frame at a time
// Notes: Reserved bits masked unless rude is set
`timescale 1ns/1ps
module arr_host
(
  // Clock
  input wire logic    sys_clk,
  // Register frames
  output logic        reg_wr,
  output logic        reg_rd_start,
  output logic        reg_rd_end,
  output logic [7:0]  reg_addr,
  output logic [15:0] reg_wdata
);
  logic rude;
  initial
  begin
    rude = 1'b0;
    reg_wr = 1'b0;
    reg_rd_start = 1'b0;
    reg_rd_end = 1'b0;
    reg_addr = 8'hFF;
    reg_wdata = 16'hFFFF;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= rude ? d : d & 16'hFFED;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // Returns at the edge that captures the answer
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd_start <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd_start <= 1'b0;
    reg_addr <= ~a;
  endtask
  task automatic fin;
    @(posedge sys_clk);
    reg_rd_end <= 1'b1;
    @(posedge sys_clk);
    reg_rd_end <= 1'b0;
  endtask
endmodule

// File: test/arr_readout_bench.sv
// Purpose: Self-checking bench for arr_readout
// Assumes: Five monitored words
// Notes: Host model drives all register frames
`timescale 1ns/1ps
module arr_readout_bench;
  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  logic         conv_valid = 1'b0;
  logic [23:0]  conv_raw = 24'h000000;
  logic         polarity_select = 1'b0;
  logic [7:0]   conv_status = 8'h05;
  logic [119:0] watched_regs = 120'h0;
  logic         reg_wr, reg_rd_start, reg_rd_end, xfer_extra_byte_q, rd_use_xor_q;
  logic         rd_use_crc_q, wr_use_crc_q, ready_n_q, integ_error_q;
  logic [7:0]   reg_addr;
  logic [15:0]  reg_wdata, ifmode_q;
  logic [31:0]  reg_rdata_q;
  logic [5:0]   reg_rlen_q;
  int           err_count = 0;
  int           comparisons = 0;
  always #4 sys_clk = ~sys_clk;
  arr_host host (.sys_clk, .reg_wr, .reg_rd_start, .reg_rd_end, .reg_addr, .reg_wdata);
  arr_readout #(.NUM_REGS(5)) dut (.sys_clk, .rst, .reg_wr, .reg_rd_start, .reg_rd_end, .reg_addr, .reg_wdata,
    .reg_rdata_q, .reg_rlen_q, .xfer_extra_byte_q, .rd_use_xor_q, .rd_use_crc_q, .wr_use_crc_q, .conv_valid,
    .conv_raw, .polarity_select, .conv_status, .watched_regs, .ready_n_q, .integ_error_q, .ifmode_q);
  task automatic close_out;
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] l, input logic [31:0] m);
    host.rd(a);
    #1 chk("rdata", reg_rdata_q & m, e);
    chk("rlen", 32'(reg_rlen_q), l);
    host.fin();
  endtask
  task automatic conv(input logic [23:0] r, input logic p);
    @(posedge sys_clk);
    conv_valid <= 1'b1;
    conv_raw <= r;
    polarity_select <= p;
    @(posedge sys_clk);
    conv_valid <= 1'b0;
    conv_raw <= ~r;
    repeat (50) if (ready_n_q !== 1'b0) @(posedge sys_clk) #1;
    if (ready_n_q !== 1'b0)
    begin
      chk("conv_ready", 32'(ready_n_q), 32'h0);
      close_out();
    end
  endtask
  task automatic t_result;
    conv(24'hA5B6C7, 1'b0);
    rdc(8'h04, 32'h00A5B6C7, 32'h18, 32'hFFFFFFFF);
    chk("ready", 32'(ready_n_q), 32'h1);
    host.rd(8'h04);
    @(posedge sys_clk);
    conv_valid <= 1'b1;
    @(posedge sys_clk);
    conv_valid <= 1'b0;
    host.fin();
    repeat (3) @(posedge sys_clk);
    #1 chk("dropped", 32'(ready_n_q), 32'h1);
    rdc(8'h04, 32'h00A5B6C7, 32'h18, 32'hFFFFFFFF);
    conv(24'h800002, 1'b1);
    rdc(8'h04, 32'h00400001, 32'h18, 32'hFFFFFFFF);
    host.wr(8'h02, 16'h0001);
    conv(24'hABCDEF, 1'b0);
    rdc(8'h04, 32'h0000ABCD, 32'h10, 32'hFFFFFFFF);
    host.wr(8'h02, 16'h0041);
    conv(24'h135790, 1'b0);
    rdc(8'h04, 32'h00135705, 32'h18, 32'hFFFFFFFF);
    host.wr(8'h02, 16'h0040);
    conv(24'h2468AC, 1'b0);
    rdc(8'h04, 32'h2468AC05, 32'h20, 32'hFFFFFFFF);
  endtask
  task automatic t_modes;
    int c;
    for (c = 0; c < 4; c++)
    begin
      host.wr(8'h02, 16'(c << 2));
      repeat (2) @(posedge sys_clk);
      #1 chk("extra", 32'(xfer_extra_byte_q), 32'(c == 1 || c == 2));
      chk("scheme", 32'({rd_use_xor_q, rd_use_crc_q, wr_use_crc_q}), 32'({c == 1, c == 2, c == 1 || c == 2}));
    end
  endtask
  task automatic t_integ;
    logic [23:0] x;
    int i;
    x = 24'h000000;
    @(posedge sys_clk);
    for (i = 0; i < 5; i++)
    begin
      watched_regs[i*24 +: 24] <= 24'h111111 * 24'(i + 1);
      x ^= 24'h111111 * 24'(i + 1);
    end
    rdc(8'h7F, 32'h0, 32'h0, 32'h0);
    rdc(8'h03, 32'h0, 32'h18, 32'hFFFFFFFF);
    host.wr(8'h02, 16'h0020);
    repeat (3) @(posedge sys_clk);
    rdc(8'h03, {8'h00, x}, 32'h18, 32'hFFFFFFFF);
    host.rude = 1'b1;
    host.wr(8'h02, 16'h0036);
    host.rude = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 chk("mode", 32'(ifmode_q), 32'h24);
    chk("integ", 32'(integ_error_q), 32'h0);
    rdc(8'h02, 32'h00000024, 32'h10, 32'hFFFFFFFF);
    @(posedge sys_clk);
    watched_regs[0] <= ~watched_regs[0];
    repeat (3) @(posedge sys_clk);
    #1 chk("integ", 32'(integ_error_q), 32'h1);
    rdc(8'h00, 32'h0000008D, 32'h08, 32'hFFFFFFFF);
    host.wr(8'h02, 16'h0000);
    repeat (2) @(posedge sys_clk);
    #1 chk("integ", 32'(integ_error_q), 32'h0);
    rdc(8'h03, 32'h0, 32'h18, 32'hFFFFFFFF);
  endtask
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_result();
    t_modes();
    t_integ();
    close_out();
  end
endmodule
bind arr_readout arr_readout_props props (.sys_clk, .rst, .reg_wr, .reg_rd_start, .reg_rd_end, .reg_addr, .reg_wdata,
  .reg_rlen_q, .xfer_extra_byte_q, .rd_use_xor_q, .rd_use_crc_q, .wr_use_crc_q, .ready_n_q, .integ_error_q, .ifmode_q,
  .conv_valid);
